// file: design/rmpc_cfg.svh
// Constants and timing counts for the regulator mode and phase control block.
`ifndef RMPC_CFG_SVH
`define RMPC_CFG_SVH
`define RMPC_CLK_MHZ 100
`define RMPC_BOOT_EXIT_PWM_US 20
`define RMPC_BOOT_EXIT_PWM_CYC (`RMPC_BOOT_EXIT_PWM_US * `RMPC_CLK_MHZ)
`define RMPC_PGOOD_DELAY_MS 5
`define RMPC_PGOOD_DELAY_CYC (`RMPC_PGOOD_DELAY_MS * 1000 * `RMPC_CLK_MHZ)
`define RMPC_SLOW_DIV 8
`define RMPC_SYNC_DEPTH 2
`endif

// file: design/rmpc_pkg.sv
// Types shared by the regulator mode and phase control block.
`default_nettype none
package rmpc_pkg;
  typedef enum logic [2:0] {
    RMPC_OFF,
    RMPC_START,
    RMPC_BOOT,
    RMPC_BOOT_EXIT,
    RMPC_RUN,
    RMPC_SOFT_OFF,
    RMPC_FAULT
  } rmpc_state_type;

  // Mode inputs after synchronisation.
  typedef struct packed {
    logic shutdown_n;
    logic override_hv;
    logic skip_req;
    logic power_state_n;
    logic one_phase_strap;
    logic freq_low;
  } rmpc_mode_in_type;

  // Drive gating and protection controls.
  typedef struct packed {
    logic ph1_en;
    logic ph2_en;
    logic skip_mode;
    logic uv_prot_en;
    logic overlap_en;
    logic boost_chg_en;
  } rmpc_drive_type;
endpackage
`default_nettype wire

// file: design/rmpc_sync.sv
// Two-flop synchroniser for a group of level inputs.
`timescale 1ns/10ps
`default_nettype none
`include "rmpc_cfg.svh"
module rmpc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("rmpc_sync: width must be at least one");
  end

  // Only the second flop is read outside, since the first may be metastable.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: design/rmpc_top.sv
// Mode, phase-count and power-state sequencer of a two-phase core regulator.
`timescale 1ns/10ps
`default_nettype none
`include "rmpc_cfg.svh"
module rmpc_top #(
  parameter int BOOT_EXIT_CYC = `RMPC_BOOT_EXIT_PWM_CYC,
  parameter int PGOOD_DELAY_CYC = `RMPC_PGOOD_DELAY_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic shutdown_control_n_in,
  input wire logic shutdown_override_in,
  input wire logic skip_mode_request_in,
  input wire logic power_state_indicator_n_in,
  input wire logic phase_two_sense_positive_in,
  input wire logic frequency_set_low_current_in,
  input wire logic feedback_in_reg_in,
  input wire logic feedback_above_upper_in,
  input wire logic ramp_done_in,
  input wire logic code_transition_in,
  input wire logic down_transition_in,
  input wire logic blank_done_in,
  output logic [2:0] slew_div_out,
  output logic ramp_up_out,
  output logic ramp_down_out,
  output logic clock_enable_out_n,
  output logic power_good_out,
  output logic power_good_oe_out,
  output logic frequency_set_hiz_out,
  output logic fault_latch_out,
  output logic low_side_drive_en_out,
  output logic high_side_drive_en_out,
  output rmpc_pkg::rmpc_drive_type drive_out
);
  // A count below one would wrap the unsigned end-of-count compares.
  if (BOOT_EXIT_CYC < 1 || PGOOD_DELAY_CYC < 1) begin : g_bad_counts
    $error("rmpc_top: counts must be at least one cycle");
  end

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  rmpc_pkg::rmpc_mode_in_type raw, syn;
  logic syn_reg, syn_above, syn_ramp, syn_code, syn_down, syn_blank;

  assign raw = '{shutdown_n: shutdown_control_n_in, override_hv: shutdown_override_in,
                 skip_req: skip_mode_request_in, power_state_n: power_state_indicator_n_in,
                 one_phase_strap: phase_two_sense_positive_in,
                 freq_low: frequency_set_low_current_in};

  // One shared synchroniser keeps every input on the same two-edge latency.
  rmpc_sync #(.WIDTH(12), .RST_VAL(12'h000)) rmpc_sync_i (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .d_in({raw, feedback_in_reg_in, feedback_above_upper_in, ramp_done_in,
           code_transition_in, down_transition_in, blank_done_in}),
    .q_out({syn, syn_reg, syn_above, syn_ramp, syn_code, syn_down, syn_blank})
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  rmpc_pkg::rmpc_state_type state_r, state_nxt;
  logic [31:0] cnt_r;
  logic pg_delay_done;

  assign pg_delay_done = (cnt_r >= 32'(PGOOD_DELAY_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rmpc_pkg::RMPC_OFF: begin
        if (syn.shutdown_n) begin
          state_nxt = rmpc_pkg::RMPC_START;
        end
      end
      rmpc_pkg::RMPC_START: begin
        if (!syn.shutdown_n) begin
          state_nxt = rmpc_pkg::RMPC_SOFT_OFF;
        end else if (syn_ramp) begin
          state_nxt = rmpc_pkg::RMPC_BOOT;
        end
      end
      rmpc_pkg::RMPC_BOOT: begin
        if (!syn.shutdown_n) begin
          state_nxt = rmpc_pkg::RMPC_SOFT_OFF;
        end else if (syn_code) begin
          state_nxt = rmpc_pkg::RMPC_BOOT_EXIT;
        end
      end
      rmpc_pkg::RMPC_BOOT_EXIT: begin
        if (!syn.shutdown_n) begin
          state_nxt = rmpc_pkg::RMPC_SOFT_OFF;
        end else if (!syn_code && cnt_r >= 32'(BOOT_EXIT_CYC - 1)) begin
          state_nxt = rmpc_pkg::RMPC_RUN;
        end
      end
      rmpc_pkg::RMPC_RUN: begin
        if (!syn.shutdown_n) begin
          state_nxt = rmpc_pkg::RMPC_SOFT_OFF;
        end
      end
      rmpc_pkg::RMPC_SOFT_OFF: begin
        if (syn.shutdown_n) begin
          state_nxt = rmpc_pkg::RMPC_START;
        end else if (syn_ramp) begin
          state_nxt = rmpc_pkg::RMPC_OFF;
        end
      end
      rmpc_pkg::RMPC_FAULT: begin
        if (syn.override_hv || !syn.shutdown_n) begin
          state_nxt = rmpc_pkg::RMPC_OFF;
        end
      end
      default: state_nxt = rmpc_pkg::RMPC_OFF;
    endcase
    // The open-timing fault overrides every state, so it comes after the case.
    if (syn.freq_low && syn.shutdown_n && !syn.override_hv) begin
      state_nxt = rmpc_pkg::RMPC_FAULT;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= rmpc_pkg::RMPC_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Counts the boot-exit PWM hold while in boot exit, else the power-good delay.
  // It stops at the power-good delay so that it never wraps in a long run.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 32'h0000_0000;
    end else if (state_nxt != state_r) begin
      cnt_r <= 32'h0000_0000;
    end else if (state_r == rmpc_pkg::RMPC_BOOT_EXIT && syn_code) begin
      cnt_r <= 32'h0000_0000;
    end else if (!pg_delay_done || state_r == rmpc_pkg::RMPC_BOOT_EXIT) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Fault latch
  // ----------------------------------------------------------------
  // Set and clear never meet: the set is gated off inside the override band.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_latch_out <= 1'b0;
    end else if (syn.freq_low && syn.shutdown_n && !syn.override_hv) begin
      fault_latch_out <= 1'b1;
    end else if (syn.override_hv) begin
      fault_latch_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Mode and phase selection
  // ----------------------------------------------------------------
  // Skip mode is kept as a flop so PWM is re-entered only once in regulation.
  logic skip_r, skip_nxt;
  logic run_like;

  assign run_like = (state_r == rmpc_pkg::RMPC_RUN);

  always_comb begin
    skip_nxt = skip_r;
    if (state_r == rmpc_pkg::RMPC_START || state_r == rmpc_pkg::RMPC_BOOT) begin
      skip_nxt = 1'b1;
    end else if (state_r == rmpc_pkg::RMPC_BOOT_EXIT ||
                 state_r == rmpc_pkg::RMPC_SOFT_OFF) begin
      skip_nxt = 1'b0;
    end else if (run_like && syn.skip_req) begin
      skip_nxt = 1'b1;
    end else if (run_like && syn_reg) begin
      skip_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= skip_nxt;
    end
  end

  // The strap wins in every state, so a single-phase board never enables phase two.
  logic active, two_phase;

  assign active = (state_r != rmpc_pkg::RMPC_OFF) && (state_r != rmpc_pkg::RMPC_FAULT);

  always_comb begin
    if (syn.one_phase_strap) begin
      two_phase = 1'b0;
    end else if (!run_like) begin
      two_phase = 1'b1;
    end else begin
      two_phase = !syn.skip_req && syn.power_state_n;
    end
  end

  // Drive gates move together on one edge so no partial phase state appears.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_out <= '0;
      low_side_drive_en_out <= 1'b0;
      high_side_drive_en_out <= 1'b0;
    end else begin
      drive_out.ph1_en <= active;
      drive_out.ph2_en <= active && two_phase;
      drive_out.skip_mode <= skip_nxt;
      drive_out.uv_prot_en <= !syn.override_hv;
      drive_out.overlap_en <= !syn.override_hv;
      drive_out.boost_chg_en <= !syn.override_hv && active;
      low_side_drive_en_out <= active;
      high_side_drive_en_out <= active;
    end
  end

  // ----------------------------------------------------------------
  // Slew control
  // ----------------------------------------------------------------
  // Startup and soft-shutdown share the one slow rate.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      slew_div_out <= 3'h0;
      ramp_up_out <= 1'b0;
      ramp_down_out <= 1'b0;
      frequency_set_hiz_out <= 1'b1;
    end else begin
      ramp_up_out <= (state_nxt == rmpc_pkg::RMPC_START);
      ramp_down_out <= (state_nxt == rmpc_pkg::RMPC_SOFT_OFF);
      if (state_nxt == rmpc_pkg::RMPC_START || state_nxt == rmpc_pkg::RMPC_SOFT_OFF) begin
        slew_div_out <= 3'(`RMPC_SLOW_DIV - 1);
      end else begin
        slew_div_out <= 3'h0;
      end
      frequency_set_hiz_out <= !syn.shutdown_n;
    end
  end

  // ----------------------------------------------------------------
  // Clock enable and power-good
  // ----------------------------------------------------------------
  logic blank_r, in_reg_eff, powered_up_r;

  // Upper-threshold blanking over a downward skip-mode transition.
  // A new downward step that starts as the last one settles wins over the clear.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      blank_r <= 1'b0;
    end else if (skip_r && syn_down) begin
      blank_r <= 1'b1;
    end else if (syn_blank && syn_reg) begin
      blank_r <= 1'b0;
    end
  end

  // The next skip value is used so the threshold is ignored from the entry edge on.
  assign in_reg_eff = syn_reg && (!syn_above || skip_nxt || blank_r);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      powered_up_r <= 1'b0;
    end else if (!run_like && state_r != rmpc_pkg::RMPC_BOOT_EXIT) begin
      powered_up_r <= 1'b0;
    end else if (pg_delay_done && run_like) begin
      powered_up_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      clock_enable_out_n <= 1'b1;
      power_good_out <= 1'b0;
      power_good_oe_out <= 1'b1;
    end else if (!syn.shutdown_n || state_r == rmpc_pkg::RMPC_START ||
                 state_r == rmpc_pkg::RMPC_BOOT || state_r == rmpc_pkg::RMPC_SOFT_OFF ||
                 !active) begin
      clock_enable_out_n <= 1'b1;
      power_good_out <= 1'b0;
      power_good_oe_out <= 1'b1;
    end else if (syn_code || state_r == rmpc_pkg::RMPC_BOOT_EXIT) begin
      clock_enable_out_n <= 1'b0;
      power_good_out <= powered_up_r;
      power_good_oe_out <= !powered_up_r;
    end else if (!powered_up_r) begin
      clock_enable_out_n <= !in_reg_eff;
      power_good_out <= 1'b0;
      power_good_oe_out <= 1'b1;
    end else begin
      clock_enable_out_n <= !in_reg_eff;
      power_good_out <= in_reg_eff;
      power_good_oe_out <= !in_reg_eff;
    end
  end
endmodule
`default_nettype wire

// file: tb/rmpc_sva.sv
// Assertion checker bound to the mode and phase sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "rmpc_cfg.svh"
module rmpc_sva #(
  parameter int BOOT_EXIT_CYC = `RMPC_BOOT_EXIT_PWM_CYC,
  parameter int PGOOD_DELAY_CYC = `RMPC_PGOOD_DELAY_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic shutdown_control_n_in,
  input wire logic shutdown_override_in,
  input wire logic skip_mode_request_in,
  input wire logic phase_two_sense_positive_in,
  input wire logic code_transition_in,
  input wire logic [2:0] slew_div_out,
  input wire logic ramp_up_out,
  input wire logic ramp_down_out,
  input wire logic clock_enable_out_n,
  input wire logic power_good_out,
  input wire logic power_good_oe_out,
  input wire logic fault_latch_out,
  input wire logic low_side_drive_en_out,
  input wire logic high_side_drive_en_out,
  input wire rmpc_pkg::rmpc_drive_type drive_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  property p_strap;
    phase_two_sense_positive_in [*5] |-> !drive_out.ph2_en;
  endproperty
  a_strap: assert property (p_strap) else $error("phase two on");
  property p_slow_up;
    ramp_up_out |-> slew_div_out == 3'(`RMPC_SLOW_DIV - 1);
  endproperty
  a_slow_up: assert property (p_slow_up) else $error("fast ramp up");
  property p_slow_dn;
    ramp_down_out |-> slew_div_out == 3'(`RMPC_SLOW_DIV - 1);
  endproperty
  a_slow_dn: assert property (p_slow_dn) else $error("fast ramp down");
  property p_ovr;
    shutdown_override_in [*5] |-> !fault_latch_out && !drive_out.uv_prot_en
      && !drive_out.overlap_en && !drive_out.boost_chg_en;
  endproperty
  a_ovr: assert property (p_ovr) else $error("override ignored");
  property p_fault;
    fault_latch_out [*2] |-> !low_side_drive_en_out && !high_side_drive_en_out;
  endproperty
  a_fault: assert property (p_fault) else $error("drivers on in fault");
  property p_off;
    !shutdown_control_n_in [*5] |-> clock_enable_out_n;
  endproperty
  a_off: assert property (p_off) else $error("clock enable in shutdown");
  property p_code;
    (code_transition_in && shutdown_control_n_in && !ramp_up_out && !ramp_down_out
      && !fault_latch_out) [*5] |-> !clock_enable_out_n;
  endproperty
  a_code: assert property (p_code) else $error("clock enable off in transition");
  property p_inv;
    power_good_out |-> !clock_enable_out_n && !power_good_oe_out;
  endproperty
  a_inv: assert property (p_inv) else $error("power good not inverse");
  property p_skip;
    (skip_mode_request_in && power_good_out) [*5] |-> drive_out.skip_mode;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not entered");
  property p_boot;
    ramp_up_out |-> !power_good_out && power_good_oe_out && clock_enable_out_n;
  endproperty
  a_boot: assert property (p_boot) else $error("power good in startup");
  c_up: cover property ($rose(ramp_up_out));
  c_pg: cover property ($rose(power_good_out));
  c_fault: cover property ($rose(fault_latch_out));
  c_code: cover property (code_transition_in && power_good_out && !power_good_oe_out);
endmodule
bind rmpc_top rmpc_sva #(
  .BOOT_EXIT_CYC(BOOT_EXIT_CYC),
  .PGOOD_DELAY_CYC(PGOOD_DELAY_CYC)
) rmpc_sva_i (
  .mclk_in(mclk_in),
  .rst_in(rst_in),
  .shutdown_control_n_in(shutdown_control_n_in),
  .shutdown_override_in(shutdown_override_in),
  .skip_mode_request_in(skip_mode_request_in),
  .phase_two_sense_positive_in(phase_two_sense_positive_in),
  .code_transition_in(code_transition_in),
  .slew_div_out(slew_div_out),
  .ramp_up_out(ramp_up_out),
  .ramp_down_out(ramp_down_out),
  .clock_enable_out_n(clock_enable_out_n),
  .power_good_out(power_good_out),
  .power_good_oe_out(power_good_oe_out),
  .fault_latch_out(fault_latch_out),
  .low_side_drive_en_out(low_side_drive_en_out),
  .high_side_drive_en_out(high_side_drive_en_out),
  .drive_out(drive_out)
);
`default_nettype wire

// file: tb/rmpc_partner.sv
// Slew controller stand-in facing the sequencer.
`timescale 1ns/10ps
`default_nettype none
module rmpc_partner #(
  parameter int RAMP_CYC = 8
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ramp_up_in,
  input wire logic ramp_down_in,
  input wire logic code_req_in,
  output logic ramp_done_out,
  output logic code_transition_out,
  output logic down_transition_out,
  output logic blank_done_out
);
  int cnt_r;
  // The slow ramp reports done after a full ramp time, counted from the start of any back-to-back up and down ramps.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 0;
    end else if (ramp_up_in || ramp_down_in) begin
      cnt_r <= cnt_r + 1;
    end else begin
      cnt_r <= 0;
    end
  end
  assign ramp_done_out = (ramp_up_in || ramp_down_in) && cnt_r >= RAMP_CYC;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      code_transition_out <= 1'b0;
      down_transition_out <= 1'b0;
      blank_done_out <= 1'b1;
    end else begin
      code_transition_out <= code_req_in;
      down_transition_out <= code_req_in;
      blank_done_out <= !code_req_in;
    end
  end
endmodule
`default_nettype wire

// file: tb/regulator_mode_phase_control_bench.sv
// Self-checking bench for the mode and phase sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "rmpc_cfg.svh"
module regulator_mode_phase_control_bench;
  localparam int BOOT_CYC = 12;
  localparam int PG_CYC = 20;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ctl_n = 1'b0, ovr = 1'b0, req = 1'b0, pst_n = 1'b1, strap = 1'b0;
  logic low_cur = 1'b0, in_reg = 1'b1, above = 1'b0, code_req = 1'b0;
  logic ramp_done, code_tr, down_tr, blank_done, ramp_up, ramp_dn, clk_en_n, pg;
  logic pg_oe, hiz, fault, ls_en, hs_en;
  logic [2:0] slew_div;
  rmpc_pkg::rmpc_drive_type drv;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  rmpc_top #(.BOOT_EXIT_CYC(BOOT_CYC), .PGOOD_DELAY_CYC(PG_CYC)) rmpc_top_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .shutdown_control_n_in(ctl_n),
    .shutdown_override_in(ovr), .skip_mode_request_in(req),
    .power_state_indicator_n_in(pst_n), .phase_two_sense_positive_in(strap),
    .frequency_set_low_current_in(low_cur), .feedback_in_reg_in(in_reg),
    .feedback_above_upper_in(above), .ramp_done_in(ramp_done),
    .code_transition_in(code_tr), .down_transition_in(down_tr),
    .blank_done_in(blank_done), .slew_div_out(slew_div), .ramp_up_out(ramp_up),
    .ramp_down_out(ramp_dn), .clock_enable_out_n(clk_en_n), .power_good_out(pg),
    .power_good_oe_out(pg_oe), .frequency_set_hiz_out(hiz), .fault_latch_out(fault),
    .low_side_drive_en_out(ls_en), .high_side_drive_en_out(hs_en), .drive_out(drv));
  rmpc_partner rmpc_partner_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .ramp_up_in(ramp_up), .ramp_down_in(ramp_dn),
    .code_req_in(code_req), .ramp_done_out(ramp_done), .code_transition_out(code_tr),
    .down_transition_out(down_tr), .blank_done_out(blank_done));
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wrap_up();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic t_start();
    req = 1'b1;
    ctl_n = 1'b1;
    step(5);
    chk("ramp_up", ramp_up, 1'b1);
    chk("slew_div", slew_div, 3'(`RMPC_SLOW_DIV - 1));
    chk("ph1", drv.ph1_en, 1'b1);
    chk("clk_en_n", clk_en_n, 1'b1);
    step(20);
    chk("skip", drv.skip_mode, 1'b1);
    chk("ph2", drv.ph2_en, 1'b1);
    code_req = 1'b1;
    step(6);
    chk("clk_en_n", clk_en_n, 1'b0);
    chk("pg_oe", pg_oe, 1'b1);
    code_req = 1'b0;
    step(6);
    chk("skip", drv.skip_mode, 1'b0);
    chk("pg", pg, 1'b0);
    step(BOOT_CYC + PG_CYC + 8);
    chk("pg", pg, 1'b1);
    chk("clk_en_n", clk_en_n, 1'b0);
    chk("skip", drv.skip_mode, 1'b1);
    chk("slew_div", slew_div, 3'h0);
  endtask
  task automatic t_modes();
    logic [1:0] combo [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
    foreach (combo[k]) begin
      {req, pst_n} = combo[k];
      step(6);
      chk("skip", drv.skip_mode, combo[k][1]);
      chk("ph2", drv.ph2_en, !combo[k][1] && combo[k][0]);
    end
    req = 1'b1;
    above = 1'b1;
    step(6);
    chk("clk_en_n", clk_en_n, 1'b0);
    above = 1'b0;
    in_reg = 1'b0;
    req = 1'b0;
    step(6);
    chk("skip", drv.skip_mode, 1'b1);
    chk("clk_en_n", clk_en_n, 1'b1);
    in_reg = 1'b1;
    step(6);
    chk("skip", drv.skip_mode, 1'b0);
    strap = 1'b1;
    step(6);
    chk("ph2", drv.ph2_en, 1'b0);
    strap = 1'b0;
    req = 1'b1;
    code_req = 1'b1;
    step(6);
    chk("clk_en_n", clk_en_n, 1'b0);
    chk("pg_oe", pg_oe, 1'b0);
    code_req = 1'b0;
    step(6);
    chk("pg", pg, 1'b1);
  endtask
  task automatic t_off();
    req = 1'b1;
    ctl_n = 1'b0;
    step(5);
    chk("ramp_dn", ramp_dn, 1'b1);
    chk("skip", drv.skip_mode, 1'b0);
    step(20);
    chk("hiz", hiz, 1'b1);
    chk("ls_en", ls_en, 1'b0);
    chk("ph1", drv.ph1_en, 1'b0);
    chk("pg_oe", pg_oe, 1'b1);
  endtask
  task automatic t_fault();
    low_cur = 1'b1;
    step(6);
    chk("fault", fault, 1'b1);
    chk("hs_en", hs_en, 1'b0);
    low_cur = 1'b0;
    step(6);
    chk("fault", fault, 1'b1);
    ovr = 1'b1;
    step(6);
    chk("fault", fault, 1'b0);
    chk("uv_prot", drv.uv_prot_en, 1'b0);
    chk("overlap", drv.overlap_en, 1'b0);
    chk("boost", drv.boost_chg_en, 1'b0);
    ovr = 1'b0;
    ctl_n = 1'b0;
    step(25);
  endtask
  initial begin
    step(3);
    rst_in = 1'b0;
    step(2);
    t_start();
    t_modes();
    t_off();
    t_start();
    t_fault();
    wrap_up();
  end
endmodule
`default_nettype wire
